//--- hw/rfi_core.v
// radio interrupt aggregation, event flags and mask, and byte data port
`include "rfi_regs.vh"
`default_nettype none

// Notes on behaviour
// - two cpu requests: data transfer on vector 0, radio events on vector 12.
// - data request when rx byte waiting or tx port can take next byte.
// - event flags set only on rising edge of their source.
// - combined radio request also goes out as timer 1 capture trigger.
// - data request gated by its enable; radio request by main radio enable.
// - pending flags held for data request and for combined radio request.
// - combined request built from six sources, each with flag and mask bit.
// - flags update regardless of mask; mask only gates combined request.
// - radio request needs flagged, masked-in source and main enable.
// - flag bits 5..0 timeout, done, cs, pqt, cca, sync; 7:6 read zero.
// - flags reset to 0; writing 0 clears, writing 1 leaves unchanged.
// - mask uses same bit positions, 1 enables, resets 0, 7:6 zero.
// - packet-done flag also set on data path underflow or overflow.
// - data register write sends a tx byte, read returns next rx byte.
// - strobe 0x03 while idle starts transmission, calibrating first if enabled.
module rfi_core (
	// clock and reset
	input  wire       clock,
	input  wire       srst,
	// special-function register access
	input  wire [7:0] sfr_addr,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	input  wire [7:0] sfr_wdata,
	output reg  [7:0] sfr_rdata,
	// cpu interrupt enables and pending-flag clears
	input  wire       data_xfer_irq_enable,
	input  wire       radio_irq_main_enable,
	input  wire       data_xfer_pending_clr,
	input  wire       radio_main_pending_clr,
	// radio event source levels
	input  wire       ev_rx_timeout,
	input  wire       ev_packet_done,
	input  wire       ev_carrier_sense,
	input  wire       ev_preamble_quality,
	input  wire       ev_clear_channel,
	input  wire       ev_sync_detect,
	// radio state and calibration option
	input  wire       radio_idle,
	input  wire       auto_cal_enable,
	// transmit byte stream toward the modulator
	output reg        tx_valid,
	input  wire       tx_ready,
	output reg  [7:0] tx_data,
	// receive byte stream from the demodulator
	input  wire       rx_valid,
	output wire       rx_ready,
	input  wire [7:0] rx_data,
	// radio control
	output reg        tx_start,
	output reg        cal_start,
	// interrupt and trigger outputs
	output reg        data_xfer_pending,
	output reg        radio_main_pending,
	output reg        data_xfer_irq,
	output reg        radio_irq,
	output reg        timer1_capture
);

	// ----------------------------------------
	// registers and event sampling
	// ----------------------------------------
	reg  [5:0] radio_event_flags;
	reg  [5:0] radio_event_mask;
	reg  [5:0] ev_prev;
	reg  [7:0] rx_byte;
	reg        rx_full;
	reg        rx_overflow;
	reg        tx_underflow;
	reg        tx_active;
	reg        rx_accept;

	wire [5:0] ev_now;
	wire [5:0] ev_rise;
	wire [5:0] next_flags;
	wire       wr_flags;
	wire       wr_mask;
	wire       wr_data;
	wire       rd_data;
	wire       wr_strobe;
	wire       fifo_in_ready;
	wire       fifo_out_valid;
	wire [7:0] fifo_out_data;
	wire       data_req;
	wire       radio_req;

	assign ev_now = {ev_rx_timeout, ev_packet_done | rx_overflow | tx_underflow, ev_carrier_sense,
		ev_preamble_quality, ev_clear_channel, ev_sync_detect};
	assign ev_rise = ev_now & ~ev_prev;

	assign wr_flags  = sfr_wr && (sfr_addr == `RFI_ADDR_EVENT_FLAGS);
	assign wr_mask   = sfr_wr && (sfr_addr == `RFI_ADDR_EVENT_MASK);
	assign wr_data   = sfr_wr && (sfr_addr == `RFI_ADDR_DATA_PORT);
	assign rd_data   = sfr_rd && (sfr_addr == `RFI_ADDR_DATA_PORT);
	assign wr_strobe = sfr_wr && (sfr_addr == `RFI_ADDR_STROBE);

	assign next_flags = (wr_flags ? (radio_event_flags & sfr_wdata[5:0]) : radio_event_flags) | ev_rise;

	always @(posedge clock) begin
		if (srst) begin
			ev_prev           <= 6'h00;
			radio_event_flags <= `RFI_RST_EVENT_FLAGS;
			radio_event_mask  <= `RFI_RST_EVENT_MASK;
		end else begin
			ev_prev           <= ev_now;
			radio_event_flags <= next_flags;
			if (wr_mask) begin
				radio_event_mask <= sfr_wdata[5:0];
			end
		end
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	always @(posedge clock) begin
		if (srst) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			if (sfr_addr == `RFI_ADDR_EVENT_FLAGS) begin
				sfr_rdata <= {2'b00, radio_event_flags};
			end else if (sfr_addr == `RFI_ADDR_EVENT_MASK) begin
				sfr_rdata <= {2'b00, radio_event_mask};
			end else if (sfr_addr == `RFI_ADDR_DATA_PORT) begin
				sfr_rdata <= rx_byte;
			end else begin
				sfr_rdata <= 8'h00;
			end
		end
	end

	// ----------------------------------------
	// transmit path through the fifo
	// ----------------------------------------
	// write hands a tx byte
	rfi_fifo #(
		.WIDTH (`RFI_FIFO_WIDTH),
		.DEPTH (`RFI_FIFO_DEPTH),
		.AW    (`RFI_FIFO_AW)
	) u_tx_fifo (
		.clock     (clock),
		.srst      (srst),
		.in_valid  (wr_data),
		.in_ready  (fifo_in_ready),
		.in_data   (sfr_wdata),
		.out_valid (fifo_out_valid),
		.out_ready (!tx_valid || tx_ready),
		.out_data  (fifo_out_data)
	);

	// output stage keeps tx_data registered
	always @(posedge clock) begin
		if (srst) begin
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
		end else if (!tx_valid || tx_ready) begin
			tx_valid <= fifo_out_valid;
			if (fifo_out_valid) begin
				tx_data <= fifo_out_data;
			end
		end
	end

	// ----------------------------------------
	// strobes and receive byte holding
	// ----------------------------------------
	// rx byte waits in one holder; a new one while full is an overflow
	// never stalls the demodulator; a lost byte is reported as overflow instead
	assign rx_ready = rx_accept;

	always @(posedge clock) begin
		if (srst) begin
			tx_start     <= 1'b0;
			cal_start    <= 1'b0;
			tx_active    <= 1'b0;
			rx_accept    <= 1'b0;
			rx_byte      <= 8'h00;
			rx_full      <= 1'b0;
			rx_overflow  <= 1'b0;
			tx_underflow <= 1'b0;
		end else begin
			rx_accept <= 1'b1;
			tx_start  <= wr_strobe && (sfr_wdata == `RFI_STROBE_TX) && radio_idle;
			cal_start <= wr_strobe && (sfr_wdata == `RFI_STROBE_TX) && radio_idle && auto_cal_enable;
			if (wr_strobe && (sfr_wdata == `RFI_STROBE_TX) && radio_idle) begin
				tx_active <= 1'b1;
			end else if (ev_packet_done) begin
				tx_active <= 1'b0;
			end
			if (rx_valid) begin
				rx_byte <= rx_data;
			end
			if (rx_valid) begin
				rx_full <= 1'b1;
			end else if (rd_data) begin
				rx_full <= 1'b0;
			end
			rx_overflow  <= rx_valid && rx_full && !rd_data;
			tx_underflow <= tx_active && tx_ready && !tx_valid && !fifo_out_valid && !ev_packet_done;
		end
	end

	// ----------------------------------------
	// interrupt requests
	// ----------------------------------------
	// rx waiting or tx space
	// the start strobe asks for the first byte, or a polled sender would wait forever
	assign data_req = (rx_valid && !rx_full) || tx_start
		|| (tx_active && tx_valid && tx_ready && fifo_in_ready);
	assign radio_req = |(radio_event_flags & radio_event_mask);

	always @(posedge clock) begin
		if (srst) begin
			data_xfer_pending  <= 1'b0;
			radio_main_pending <= 1'b0;
			data_xfer_irq      <= 1'b0;
			radio_irq          <= 1'b0;
			timer1_capture     <= 1'b0;
		end else begin
			if (data_req) begin
				data_xfer_pending <= 1'b1;
			end else if (data_xfer_pending_clr) begin
				data_xfer_pending <= 1'b0;
			end
			// stays set while any masked-in flag remains
			if (radio_req) begin
				radio_main_pending <= 1'b1;
			end else if (radio_main_pending_clr) begin
				radio_main_pending <= 1'b0;
			end
			data_xfer_irq  <= (data_xfer_pending || data_req) && data_xfer_irq_enable;
			radio_irq      <= (radio_main_pending || radio_req) && radio_irq_main_enable;
			timer1_capture <= radio_req && radio_irq_main_enable;
		end
	end

endmodule

`default_nettype wire

//--- include/rfi_regs.vh
// register offsets, field positions and reset values of the radio interrupt and data port
`ifndef RFI_REGS_VH
`define RFI_REGS_VH

// ----------------------------------------
// special-function register offsets
// ----------------------------------------
`define RFI_ADDR_EVENT_MASK  8'h91
`define RFI_ADDR_EVENT_FLAGS 8'hE9
`define RFI_ADDR_DATA_PORT   8'hD9
`define RFI_ADDR_STROBE      8'hE1

// ----------------------------------------
// event bit positions
// ----------------------------------------
`define RFI_BIT_SYNC_DETECT      0
`define RFI_BIT_CLEAR_CHANNEL    1
`define RFI_BIT_PREAMBLE_QUALITY 2
`define RFI_BIT_CARRIER_SENSE    3
`define RFI_BIT_PACKET_DONE      4
`define RFI_BIT_RX_TIMEOUT       5
`define RFI_NUM_EVENTS           6

// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define RFI_RST_EVENT_MASK  6'h00
`define RFI_RST_EVENT_FLAGS 6'h00
`define RFI_STROBE_TX       8'h03
`define RFI_FIFO_WIDTH      8
`define RFI_FIFO_DEPTH      16
`define RFI_FIFO_AW         4

`endif

//--- hw/rfi_fifo.v
// small flip-flop fifo with valid and ready on both sides
`default_nettype none

module rfi_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	// clock and reset
	input  wire             clock,
	input  wire             srst,
	// write side
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	// read side
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);

	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;

	wire do_wr;
	wire do_rd;

	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign do_wr     = in_valid && in_ready;
	assign do_rd     = out_valid && out_ready;

	always @(posedge clock) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always @(posedge clock) begin
		if (srst) begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (do_rd) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (do_wr && !do_rd) begin
				count <= count + 1'b1;
			end else if (do_rd && !do_wr) begin
				count <= count - 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

//--- sim/rfi_checker.sv
// port-level checker of the radio interrupt and data port
`default_nettype none
module rfi_checker (
	// clock, reset and register access
	input wire logic       clock,
	input wire logic       srst,
	input wire logic [7:0] sfr_addr,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_wdata,
	input wire logic [7:0] sfr_rdata,
	// controls and outputs
	input wire logic       data_xfer_irq_enable,
	input wire logic       radio_irq_main_enable,
	input wire logic       radio_idle,
	input wire logic       auto_cal_enable,
	input wire logic       tx_valid,
	input wire logic       tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic       tx_start,
	input wire logic       cal_start,
	input wire logic       data_xfer_irq,
	input wire logic       radio_irq,
	input wire logic       timer1_capture
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst);
	sequence strobe_tx;
		sfr_wr && sfr_addr == 8'hE1 && sfr_wdata == 8'h03 ##0 radio_idle;
	endsequence
	sequence unmapped_rd;
		sfr_rd && !(sfr_addr inside {8'h91, 8'hE9, 8'hD9, 8'hE1});
	endsequence
	tx_start_a: assert property (strobe_tx |=> tx_start) else $error("strobe gave no tx start");
	cal_start_a: assert property (strobe_tx ##0 auto_cal_enable |=> cal_start) else $error("no cal start");
	no_cal_a: assert property (!auto_cal_enable |=> !cal_start) else $error("cal start without auto cal");
	radio_gate_a: assert property (!radio_irq_main_enable |=> !radio_irq) else $error("radio irq not gated");
	data_gate_a: assert property (!data_xfer_irq_enable |=> !data_xfer_irq) else $error("data irq not gated");
	capture_gate_a: assert property (!radio_irq_main_enable |=> !timer1_capture) else $error("capture ungated");
	high_bits_a: assert property (sfr_rd && sfr_addr inside {8'h91, 8'hE9} |=> sfr_rdata[7:6] == 2'b00)
		else $error("unused bits read nonzero");
	unmapped_a: assert property (unmapped_rd |=> sfr_rdata == 8'h00) else $error("unmapped read nonzero");
	no_start_a: assert property (!(sfr_wr && sfr_addr == 8'hE1 && sfr_wdata == 8'h03 && radio_idle) |=> !tx_start)
		else $error("tx start without idle tx strobe");
	tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx byte dropped while stalled");
endmodule
bind rfi_core rfi_checker u_chk (.clock(clock), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
	.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .data_xfer_irq_enable(data_xfer_irq_enable),
	.radio_irq_main_enable(radio_irq_main_enable), .radio_idle(radio_idle), .auto_cal_enable(auto_cal_enable),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_start(tx_start), .cal_start(cal_start),
	.data_xfer_irq(data_xfer_irq), .radio_irq(radio_irq), .timer1_capture(timer1_capture));
`default_nettype wire

//--- sim/rfi_radio_model.sv
// radio-side model: stalling byte sink and byte source
`default_nettype none
module rfi_radio_model (
	// clock and transmit side
	input  wire logic       clock,
	input  wire logic       slow,
	output var  logic       tx_ready,
	// receive side
	input  wire logic       send,
	input  wire logic [7:0] send_byte,
	output var  logic       rx_valid,
	output var  logic [7:0] rx_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt;
	initial begin
		{cnt, tx_ready, rx_valid, rx_data} = 12'h000;
	end
	always @(posedge clock) begin
		cnt <= cnt + 2'h1;
		// stalls three cycles in four so bytes must wait
		tx_ready <= !slow || cnt == 2'h3;
		rx_valid <= send;
		// idle data is inverted so a stale byte never looks valid
		rx_data <= send ? send_byte : ~rx_data;
	end
endmodule
`default_nettype wire

//--- sim/tb.sv
// self-checking bench of the radio interrupt and data port
`include "rfi_regs.vh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic       clock, srst, sfr_wr, sfr_rd, dx_en, rm_en, dx_clr, rm_clr, idle, acal, slow, send, rd_d;
	logic       tx_valid, tx_ready, rx_valid, rx_ready, tx_start, cal_start, dx_pend, rm_pend, dx_irq, r_irq, t1cap;
	logic [7:0] sfr_addr, sfr_wdata, send_byte, sfr_rdata, tx_data, rx_data, b;
	logic [5:0] ev;
	logic [7:0] rq[$], tq[$];
	int         mismatches, check_count, i, n;
	rfi_core u_dut (.clock(clock), .srst(srst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .data_xfer_irq_enable(dx_en), .radio_irq_main_enable(rm_en),
		.data_xfer_pending_clr(dx_clr), .radio_main_pending_clr(rm_clr), .ev_rx_timeout(ev[5]),
		.ev_packet_done(ev[4]), .ev_carrier_sense(ev[3]), .ev_preamble_quality(ev[2]), .ev_clear_channel(ev[1]),
		.ev_sync_detect(ev[0]), .radio_idle(idle), .auto_cal_enable(acal), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
		.tx_start(tx_start), .cal_start(cal_start), .data_xfer_pending(dx_pend), .radio_main_pending(rm_pend),
		.data_xfer_irq(dx_irq), .radio_irq(r_irq), .timer1_capture(t1cap));
	rfi_radio_model u_radio (.clock(clock), .slow(slow), .tx_ready(tx_ready), .send(send),
		.send_byte(send_byte), .rx_valid(rx_valid), .rx_data(rx_data));
	initial begin
		clock = 0;
		forever #4 clock = ~clock;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_lvl(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = w;
		sfr_rd = !w;
		tick(1);
		sfr_wr = 0;
		sfr_rd = 0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		rq.push_back(e);
		bus(0, a, 8'h00);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ------------------------------------------------
	// result watchers
	// ------------------------------------------------
	always @(posedge clock) rd_d <= sfr_rd;
	always @(negedge clock) if (rd_d) chk(sfr_rdata, rq.pop_front());
	always @(posedge clock) if (tx_valid && tx_ready) chk(tx_data, tq.size() ? tq.pop_front() : 8'hXX);
	initial begin
		#200000;
		mismatches++;
		results();
	end
	// ------------------------------------------------
	// stimulus
	// ------------------------------------------------
	initial begin
		{sfr_wr, sfr_rd, dx_en, rm_en, dx_clr, rm_clr, idle, acal, slow, send} = 10'h000;
		{sfr_addr, sfr_wdata, send_byte, ev} = 30'h00000000;
		{mismatches, check_count} = 0;
		srst = 1;
		void'($urandom(32'hB53F));
		tick(12);
		srst = 0;
		rd(8'h91, 8'h00);
		rd(8'hE9, 8'h00);
		rd(8'h55, 8'h00);
		chk_lvl(rx_ready, 1'b1);
		bus(1, 8'h91, 8'hFF);
		rd(8'h91, 8'h3F);
		bus(1, 8'h91, 8'h00);
		// masked sources still flag, held levels do not refire
		for (i = 0; i < 6; i++) begin
			ev[i] = 1;
			tick(6);
			bus(1, 8'hE9, 8'hFF);
			rd(8'hE9, 8'h01 << i);
			bus(1, 8'hE9, 8'h00);
			rd(8'hE9, 8'h00);
			ev[i] = 0;
		end
		chk_lvl(rm_pend, 1'b0);
		bus(1, 8'h91, 8'h10);
		rm_en = 1;
		ev[0] = 1;
		tick(6);
		chk_lvl(r_irq, 1'b0);
		ev[4] = 1;
		tick(6);
		chk_lvl(r_irq, 1'b1);
		chk_lvl(rm_pend, 1'b1);
		chk_lvl(t1cap, 1'b1);
		bus(1, 8'hE9, 8'h00);
		rm_clr = 1;
		tick(1);
		rm_clr = 0;
		ev = 6'h00;
		tick(4);
		chk_lvl(r_irq, 1'b0);
		// strobe while busy must not start
		bus(1, 8'hE1, 8'h03);
		idle = 1;
		acal = 1;
		bus(1, 8'hE1, 8'h03);
		bus(1, 8'hE1, 8'(4 + $urandom_range(251)));
		acal = 0;
		bus(1, 8'hE1, 8'h03);
		slow = 1;
		dx_en = 1;
		// length byte first, then that many random payload bytes
		// queue drained on request
		for (i = 0; i < 6; i++) begin
			b = i ? 8'($urandom) : 8'h05;
			tq.push_back(b);
			n = 0;
			while (!dx_pend && n < 40) begin
				tick(1);
				n++;
			end
			chk_lvl(dx_pend, 1'b1);
			dx_clr = 1;
			tick(1);
			dx_clr = 0;
			bus(1, 8'hD9, b);
		end
		tick(60);
		chk(8'(tq.size()), 8'h00);
		chk_lvl(dx_irq, 1'b1);
		rd(8'hE9, 8'h10);
		ev[4] = 1;
		tick(4);
		ev[4] = 0;
		bus(1, 8'hE9, 8'h00);
		dx_clr = 1;
		tick(1);
		dx_clr = 0;
		tick(2);
		rd(8'hE9, 8'h00);
		send_byte = 8'($urandom);
		send = 1;
		tick(1);
		send = 0;
		tick(4);
		chk_lvl(dx_pend, 1'b1);
		rd(8'hD9, send_byte);
		// two bytes with no read between overrun the holder
		send = 1;
		tick(2);
		send = 0;
		tick(4);
		rd(8'hE9, 8'h10);
		tick(4);
		results();
	end
endmodule
`default_nettype wire
